// File: design/sdl_pkg.sv
// Shared constants for the serial DAC load logic.
// Assumes one system clock; all pins arrive asynchronous to it.
package sdl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Word format
  localparam int          SDL_WORD_BITS   = 16;
  localparam logic [4:0]  SDL_WORD_COUNT  = 5'h10;          // Bits per word
  localparam logic [15:0] SDL_MIDSCALE    = 16'h8000;       // Zero-volt code
  localparam logic [15:0] SDL_OFFSET_FLIP = 16'h8000;       // Offset-binary sign bit

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [15:0] SDL_SHIFT_RESET = SDL_MIDSCALE;
  localparam logic [15:0] SDL_INPUT_RESET = SDL_MIDSCALE;
  localparam logic [15:0] SDL_DAC_RESET   = SDL_MIDSCALE;
  localparam logic [4:0]  SDL_COUNT_RESET = 5'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Pin vector layout seen by the synchroniser
  localparam int SDL_NUM_PINS   = 6;
  localparam int SDL_PIN_SCLK   = 0;
  localparam int SDL_PIN_FRAME  = 1;
  localparam int SDL_PIN_SERIAL_DATA_IN   = 2;
  localparam int SDL_PIN_LOAD   = 3;
  localparam int SDL_PIN_CLEAR  = 4;
  localparam int SDL_PIN_PDOWN  = 5;
  localparam logic [5:0] SDL_PIN_RESET = 6'h3b;              // Idle levels

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int SDL_SYS_CLK_MHZ    = 50;
  localparam int SDL_SCLK_MAX_MHZ   = 30;                    // Host limit
  localparam int SDL_SYNC_LATENCY   = 2;                     // Cycles pin to level

endpackage : sdl_pkg

// File: design/sdl_pin_if.sv
// Interface carrying synchronised pin levels and their edges.
// Assumes producer and consumer share the system clock.
`timescale 1ns/100ps

interface sdl_pin_if;
  import sdl_pkg::*;

  logic [SDL_NUM_PINS-1:0] level;
  logic [SDL_NUM_PINS-1:0] rise;
  logic [SDL_NUM_PINS-1:0] fall;

  // Synchroniser side
  modport src (output level, output rise, output fall);
  // Logic side
  modport dst (input level, input rise, input fall);
endinterface : sdl_pin_if

// File: design/sdl_pin_sync.sv
// Two-stage synchroniser with edge detection for every pin.
// Assumes pins toggle slower than a quarter of the system clock.
`timescale 1ns/100ps

module sdl_pin_sync
  import sdl_pkg::*;
(
  // Clock and reset
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_rst,
  // Raw pins
  input  wire logic [SDL_NUM_PINS-1:0] i_pins,
  // Synchronised view
  sdl_pin_if.src                       pin_bus
);

  typedef struct packed {
    logic [SDL_NUM_PINS-1:0] meta;
    logic [SDL_NUM_PINS-1:0] stable;
    logic [SDL_NUM_PINS-1:0] prev;
  } sdl_sync_state_t;

  sdl_sync_state_t state_reg;
  sdl_sync_state_t state_next;

  // Stage shift: meta feeds only stable
  always_comb begin
    state_next        = state_reg;
    state_next.meta   = i_pins;
    state_next.stable = state_reg.meta;
    state_next.prev   = state_reg.stable;
  end

  // State register
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= {SDL_PIN_RESET, SDL_PIN_RESET, SDL_PIN_RESET};
    end else begin
      state_reg <= state_next;
    end
  end

  // Edge pulses from the stable and previous stages
  for (genvar g = 0; g < SDL_NUM_PINS; g++) begin : g_edge
    assign pin_bus.level[g] = state_reg.stable[g];
    assign pin_bus.rise[g]  = state_reg.stable[g] & ~state_reg.prev[g];
    assign pin_bus.fall[g]  = ~state_reg.stable[g] & state_reg.prev[g];
  end

endmodule // sdl_pin_sync

// File: design/sdl_shift_path.sv
// Input shift register, bit counter and serial data out source.
// Assumes edges arrive from the pin synchroniser on the same clock.
`timescale 1ns/100ps

module sdl_shift_path
  import sdl_pkg::*;
(
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  // Synchronised pins
  sdl_pin_if.dst           pin_bus,
  // Readback source
  input  wire logic [15:0] i_dac_code,
  // Word out
  output logic      [15:0] o_word,
  output logic             o_word_done,
  output logic             o_shift_pulse,
  output logic             o_sdo_bit
);

  typedef struct packed {
    logic [15:0] shift;
    logic [4:0]  count;
  } sdl_shift_state_t;

  sdl_shift_state_t state_reg;
  sdl_shift_state_t state_next;
  logic             frame_fall;
  logic             shift_now;

  // Shift only inside a frame, on serial clock falls
  assign frame_fall = pin_bus.fall[SDL_PIN_FRAME];
  assign shift_now  = ~pin_bus.level[SDL_PIN_FRAME] & pin_bus.fall[SDL_PIN_SCLK] & ~frame_fall;

  // Next state
  always_comb begin
    state_next = state_reg;
    if (frame_fall) begin
      state_next.shift = i_dac_code;
      state_next.count = SDL_COUNT_RESET;
    end else if (shift_now) begin
      state_next.shift = {state_reg.shift[14:0], pin_bus.level[SDL_PIN_SERIAL_DATA_IN]};
      if (state_reg.count != SDL_WORD_COUNT) begin
        state_next.count = state_reg.count + 5'h01;
      end
    end
  end

  // State register
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= {SDL_SHIFT_RESET, SDL_COUNT_RESET};
    end else begin
      state_reg <= state_next;
    end
  end

  // Outgoing bit is the register MSB: readback first, then input delayed 16
  assign o_sdo_bit     = state_reg.shift[15];
  assign o_word        = state_reg.shift;
  assign o_word_done   = pin_bus.rise[SDL_PIN_FRAME] & (state_reg.count == SDL_WORD_COUNT);
  assign o_shift_pulse = shift_now;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_shift_in;
    @(posedge i_sys_clk) disable iff (i_rst)
    shift_now |=> state_reg.shift == {$past(state_reg.shift[14:0]), $past(pin_bus.level[SDL_PIN_SERIAL_DATA_IN])};
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("Shift register did not take the data bit");

  property p_idle_hold;
    @(posedge i_sys_clk) disable iff (i_rst)
    (pin_bus.level[SDL_PIN_FRAME] && !frame_fall) |=> $stable(state_reg.shift);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("Shift register moved outside a frame");

  property p_readback_load;
    @(posedge i_sys_clk) disable iff (i_rst)
    frame_fall |=> o_sdo_bit == $past(i_dac_code[15]);
  endproperty
  a_readback_load: assert property (p_readback_load) else $error("Readback MSB not presented");

  property p_count_limit;
    @(posedge i_sys_clk) disable iff (i_rst)
    state_reg.count <= SDL_WORD_COUNT;
  endproperty
  a_count_limit: assert property (p_count_limit) else $error("Bit count overran");

  c_chain_pass: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    shift_now && state_reg.count == SDL_WORD_COUNT);

endmodule // sdl_shift_path

// File: design/sdl_dac_load.sv
// Top of the serial DAC load logic: pins in, DAC code and serial out.
// Assumes a 50 MHz system clock and a serial clock far slower than it.
`timescale 1ns/100ps

module sdl_dac_load
  import sdl_pkg::*;
(
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  // Serial link pins
  input  wire logic        i_frame_sel_n,
  input  wire logic        i_serial_clk,
  input  wire logic        i_serial_data_in,
  // Control pins
  input  wire logic        i_load_output_strobe_n,
  input  wire logic        i_clear_output_n,
  input  wire logic        i_power_down_n,
  // Open-drain serial data out
  output logic             o_serial_data_out,
  output logic             o_serial_data_out_oe,
  // Converter side
  output logic      [15:0] o_input_code,
  output logic      [15:0] o_dac_code,
  output logic      [15:0] o_ladder_code,
  output logic      [15:0] o_bipolar_code,
  output logic             o_output_cleared,
  output logic             o_power_down
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and shift path

  sdl_pin_if pin_bus ();

  logic [SDL_NUM_PINS-1:0] raw_pins;
  logic [15:0]             word;
  logic                    word_done;
  logic                    shift_pulse;
  logic                    sdo_bit;

  // Pack pins in package order
  always_comb begin
    raw_pins                 = SDL_PIN_RESET;
    raw_pins[SDL_PIN_SCLK]   = i_serial_clk;
    raw_pins[SDL_PIN_FRAME]  = i_frame_sel_n;
    raw_pins[SDL_PIN_SERIAL_DATA_IN]   = i_serial_data_in;
    raw_pins[SDL_PIN_LOAD]   = i_load_output_strobe_n;
    raw_pins[SDL_PIN_CLEAR]  = i_clear_output_n;
    raw_pins[SDL_PIN_PDOWN]  = i_power_down_n;
  end

  sdl_pin_sync u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_pins    (raw_pins),
    .pin_bus   (pin_bus.src)
  );

  sdl_shift_path u_shift (
    .i_sys_clk     (i_sys_clk),
    .i_rst         (i_rst),
    .pin_bus       (pin_bus.dst),
    .i_dac_code    (o_dac_code),
    .o_word        (word),
    .o_word_done   (word_done),
    .o_shift_pulse (shift_pulse),
    .o_sdo_bit     (sdo_bit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Load state

  typedef struct packed {
    logic [15:0] input_reg;
    logic [15:0] dac_reg;
    logic [15:0] ladder_reg;
    logic [15:0] bipolar_reg;
    logic        sync_mode;
    logic        cleared;
    logic        power_down;
  } sdl_load_state_t;

  sdl_load_state_t state_reg;
  sdl_load_state_t state_next;
  logic            frame_high;
  logic            load_low;
  logic            load_fall;
  logic            clear_low;
  logic            clear_fall;
  logic            dac_load;

  assign frame_high = pin_bus.level[SDL_PIN_FRAME];
  assign load_low   = ~pin_bus.level[SDL_PIN_LOAD];
  assign load_fall  = pin_bus.fall[SDL_PIN_LOAD];
  assign clear_low  = ~pin_bus.level[SDL_PIN_CLEAR];
  assign clear_fall = pin_bus.fall[SDL_PIN_CLEAR];

  // Next state
  always_comb begin
    state_next = state_reg;
    dac_load   = 1'b0;
    // Note whether load strobe was low during the shifting
    if (pin_bus.fall[SDL_PIN_FRAME]) begin
      state_next.sync_mode = load_low;
    end else if (shift_pulse && load_low) begin
      state_next.sync_mode = 1'b1;
    end
    // Completed word: input register, and DAC if synchronous
    if (word_done) begin
      state_next.input_reg = word;
      if (state_reg.sync_mode || load_low) begin
        state_next.dac_reg = word;
        dac_load           = 1'b1;
      end
    end else if (load_fall && frame_high) begin
      state_next.dac_reg = state_reg.input_reg;
      dac_load           = 1'b1;
    end
    // Clear holds zero volts until clear released and next update
    state_next.cleared = clear_fall | (state_reg.cleared & (clear_low | ~dac_load));
    state_next.ladder_reg  = state_next.cleared ? SDL_MIDSCALE : state_next.dac_reg;
    state_next.bipolar_reg = state_next.ladder_reg ^ SDL_OFFSET_FLIP;
    state_next.power_down  = ~pin_bus.level[SDL_PIN_PDOWN];
  end

  // State register
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg.input_reg   <= SDL_INPUT_RESET;
      state_reg.dac_reg     <= SDL_DAC_RESET;
      state_reg.ladder_reg  <= SDL_DAC_RESET;
      state_reg.bipolar_reg <= SDL_DAC_RESET ^ SDL_OFFSET_FLIP;
      state_reg.sync_mode   <= 1'b0;
      state_reg.cleared     <= 1'b0;
      state_reg.power_down  <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Open drain: pull low only for a zero inside a frame
  assign o_serial_data_out    = 1'b0;
  assign o_serial_data_out_oe = ~frame_high & ~sdo_bit;
  assign o_input_code         = state_reg.input_reg;
  assign o_dac_code           = state_reg.dac_reg;
  assign o_ladder_code        = state_reg.ladder_reg;
  assign o_bipolar_code       = state_reg.bipolar_reg;
  assign o_output_cleared     = state_reg.cleared;
  assign o_power_down         = state_reg.power_down;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  property p_word_to_input;
    word_done |=> o_input_code == $past(word);
  endproperty
  a_word_to_input: assert property (p_word_to_input) else $error("Word not moved to input register");

  property p_sync_update;
    (word_done && (state_reg.sync_mode || load_low)) |=> o_dac_code == $past(word);
  endproperty
  a_sync_update: assert property (p_sync_update) else $error("Synchronous update missed");

  property p_async_hold;
    (word_done && !state_reg.sync_mode && !load_low) |=> $stable(o_dac_code);
  endproperty
  a_async_hold: assert property (p_async_hold) else $error("DAC changed without load strobe");

  property p_async_update;
    (load_fall && frame_high && !word_done) |=> o_dac_code == $past(o_input_code);
  endproperty
  a_async_update: assert property (p_async_update) else $error("Load strobe fall did not update DAC");

  property p_clear_zero;
    clear_fall |=> (o_ladder_code == SDL_MIDSCALE) && $stable(o_input_code) && o_output_cleared;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("Clear did not force zero volts");

  property p_bipolar;
    o_bipolar_code == (o_ladder_code ^ SDL_OFFSET_FLIP);
  endproperty
  a_bipolar: assert property (p_bipolar) else $error("Offset binary mapping broken");

  property p_pin_to_power_down;
    $fell(i_power_down_n) |-> ##3 o_power_down;
  endproperty
  a_pin_to_power_down: assert property (p_pin_to_power_down) else $error("Power-down not entered");

  property p_sdo_in_frame;
    o_serial_data_out_oe |-> !frame_high && !sdo_bit;
  endproperty
  a_sdo_in_frame: assert property (p_sdo_in_frame) else $error("Serial out driven outside a frame");

  property p_dac_only_on_load;
    $changed(o_dac_code) |-> $past(dac_load);
  endproperty
  a_dac_only_on_load: assert property (p_dac_only_on_load) else $error("DAC register changed spuriously");

  // Ladder, clear, load-source, serial-out and power-down checks
  property p_ladder_follows;
    !o_output_cleared |-> o_ladder_code == o_dac_code;
  endproperty
  a_ladder_follows: assert property (p_ladder_follows) else $error("Ladder code not following DAC");

  property p_cleared_ladder;
    o_output_cleared |-> o_ladder_code == SDL_MIDSCALE;
  endproperty
  a_cleared_ladder: assert property (p_cleared_ladder) else $error("Cleared output not at zero volts");

  property p_clear_holds;
    (o_output_cleared && clear_low) |=> o_output_cleared;
  endproperty
  a_clear_holds: assert property (p_clear_holds) else $error("Clear dropped while pin low");

  property p_clear_release;
    (o_output_cleared && !clear_low && dac_load) |=> !o_output_cleared;
  endproperty
  a_clear_release: assert property (p_clear_release) else $error("Clear not ended by DAC update");

  property p_clear_keeps_dac;
    (clear_fall && !dac_load) |=> $stable(o_dac_code);
  endproperty
  a_clear_keeps_dac: assert property (p_clear_keeps_dac) else $error("Clear disturbed DAC register");

  property p_input_only_on_word;
    $changed(o_input_code) |-> $past(word_done);
  endproperty
  a_input_only_on_word: assert property (p_input_only_on_word) else $error("Input register changed spuriously");

  property p_word_done_frame;
    word_done |-> frame_high;
  endproperty
  a_word_done_frame: assert property (p_word_done_frame) else $error("Word completed inside a frame");

  property p_short_frame_drop;
    (pin_bus.rise[SDL_PIN_FRAME] && !word_done && !load_fall) |=> $stable(o_input_code) && $stable(o_dac_code);
  endproperty
  a_short_frame_drop: assert property (p_short_frame_drop) else $error("Short frame was not dropped");

  property p_load_ignored_in_frame;
    (load_fall && !frame_high) |=> $stable(o_dac_code);
  endproperty
  a_load_ignored_in_frame: assert property (p_load_ignored_in_frame) else $error("Strobe in frame updated DAC");

  property p_async_needs_load;
    (load_fall && frame_high && !word_done) |-> dac_load;
  endproperty
  a_async_needs_load: assert property (p_async_needs_load) else $error("Strobe fall not taken");

  property p_sync_mode_mark;
    (shift_pulse && load_low) |=> state_reg.sync_mode;
  endproperty
  a_sync_mode_mark: assert property (p_sync_mode_mark) else $error("Synchronous mode not marked");

  property p_dac_one_source;
    dac_load |=> (o_dac_code == $past(word)) || (o_dac_code == $past(o_input_code));
  endproperty
  a_dac_one_source: assert property (p_dac_one_source) else $error("DAC loaded from wrong source");

  property p_oe_idle;
    frame_high |-> !o_serial_data_out_oe && !o_serial_data_out;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("Serial out pulled outside a frame");

  property p_oe_tracks_word;
    !frame_high |-> o_serial_data_out_oe == !word[15];
  endproperty
  a_oe_tracks_word: assert property (p_oe_tracks_word) else $error("Serial out not the shift MSB");

  property p_power_follows;
    1'b1 |=> o_power_down == !$past(pin_bus.level[SDL_PIN_PDOWN]);
  endproperty
  a_power_follows: assert property (p_power_follows) else $error("Power-down not following pin");

  c_sync_load:  cover property (word_done && state_reg.sync_mode);
  c_async_load: cover property (load_fall && frame_high && !word_done);
  c_clear:      cover property (clear_fall);
  c_readback:   cover property (word_done && !state_reg.sync_mode && !load_low);

endmodule // sdl_dac_load

// File: tb/sdl_host_model.sv
// Host model: serial port controller driving frame, clock, data and load strobe.
// Assumes the data-out pin is pulled up outside the device and the system clock paces all pins.
`timescale 1ns/100ps

module sdl_host_model (
  // Clock
  input  wire logic        i_sys_clk,
  // Pulled-up serial data out pin
  input  wire logic        i_sdo_pin,
  // Link and control pins
  output logic             o_frame_sel_n,
  output logic             o_serial_clk,
  output logic             o_serial_data_in,
  output logic             o_load_output_strobe_n,
  // Pin levels seen before each clock fall, last one in bit 0
  output logic      [63:0] o_read_bits
);

  // Idle levels at time zero
  initial begin
    o_frame_sel_n          = 1'b1;
    o_serial_clk           = 1'b1;
    o_serial_data_in       = 1'b0;
    o_load_output_strobe_n = 1'b1;
    o_read_bits            = 64'h0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Wait some system clocks
  task automatic ticks(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask

  // One frame, MSB first; half sets clocks per level, so 4 gives a 160 ns period
  task automatic xfer(input int nbits, input logic [63:0] data, input logic load_lvl, input int half,
                      input logic framed);
    @(posedge i_sys_clk);
    o_frame_sel_n          <= ~framed;
    o_load_output_strobe_n <= load_lvl;
    ticks(half);
    for (int i = nbits - 1; i >= 0; i--) begin
      o_serial_data_in <= data[i];
      ticks(half);
      o_read_bits      <= {o_read_bits[62:0], i_sdo_pin};
      o_serial_clk     <= 1'b0;
      ticks(half);
      o_serial_clk     <= 1'b1;
    end
    ticks(half);
    // Frame ends only after the last fall; clock then stands high
    o_frame_sel_n    <= 1'b1;
    o_serial_data_in <= ~o_serial_data_in;               // Released line shows no stale bit
    ticks(half);
    o_load_output_strobe_n <= 1'b1;
  endtask

  // Shared strobe low pulse while frame is high
  task automatic pulse_load();
    @(posedge i_sys_clk);
    o_load_output_strobe_n <= 1'b0;
    ticks(4);
    o_load_output_strobe_n <= 1'b1;
  endtask

endmodule // sdl_host_model

// File: tb/sdl_dac_load_tb_top.sv
// Self-checking bench for the serial DAC load logic.
// Assumes the host model drives the link; clear and power-down come from here.
`timescale 1ns/100ps

module sdl_dac_load_tb_top;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        clear_n = 1'b1;
  logic        pdown_n = 1'b1;
  logic        frame_n, sclk, serial_data_in, load_n, serial_data_out, sdo_oe, cleared, pdown;
  logic [63:0] read_bits;
  logic [15:0] input_code, dac_code, ladder_code, bipolar_code;
  wire         sdo_pin = sdo_oe ? serial_data_out : 1'b1;
  int          failures = 0;
  int          num_checks = 0;

  // 50 MHz system clock
  always #10 sys_clk = ~sys_clk;

  sdl_host_model host (
    .i_sys_clk              (sys_clk),
    .i_sdo_pin              (sdo_pin),
    .o_frame_sel_n          (frame_n),
    .o_serial_clk           (sclk),
    .o_serial_data_in       (serial_data_in),
    .o_load_output_strobe_n (load_n),
    .o_read_bits            (read_bits)
  );

  sdl_dac_load DUT (
    .i_sys_clk              (sys_clk),
    .i_rst                  (rst),
    .i_frame_sel_n          (frame_n),
    .i_serial_clk           (sclk),
    .i_serial_data_in       (serial_data_in),
    .i_load_output_strobe_n (load_n),
    .i_clear_output_n       (clear_n),
    .i_power_down_n         (pdown_n),
    .o_serial_data_out      (serial_data_out),
    .o_serial_data_out_oe   (sdo_oe),
    .o_input_code           (input_code),
    .o_dac_code             (dac_code),
    .o_ladder_code          (ladder_code),
    .o_bipolar_code         (bipolar_code),
    .o_output_cleared       (cleared),
    .o_power_down           (pdown)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Compare one value
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Settle time after a pin change, past the synchroniser latency
  task automatic settle();
    repeat (6) @(posedge sys_clk);
  endtask

  // Reset for six clocks, then check the preset state
  task automatic t_reset();
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    settle();
    chk("input_code", 16'h8000, input_code);
    chk("dac_code", 16'h8000, dac_code);
    chk("ladder_code", 16'h8000, ladder_code);
    chk("bipolar_code", 16'h0000, bipolar_code);
    chk("sdo_oe", 16'h0000, {15'h0, sdo_oe});
    chk("cleared", 16'h0000, {15'h0, cleared});
    $display("test reset done");
  endtask

  // Synchronous loads of a mixed code and both boundary codes
  task automatic t_sync();
    logic [15:0] codes [3] = '{16'ha5c3, 16'h0000, 16'hffff};
    foreach (codes[k]) begin
      host.xfer(16, {48'h0, codes[k]}, 1'b0, 4, 1'b1);
      settle();
      chk("input_code", codes[k], input_code);
      chk("dac_code", codes[k], dac_code);
      chk("ladder_code", codes[k], ladder_code);
      chk("bipolar_code", codes[k] ^ 16'h8000, bipolar_code);
    end
    $display("test sync done");
  endtask

  // Slow asynchronous load with readback of the old code
  task automatic t_async();
    host.xfer(16, {48'h0, 16'h1234}, 1'b1, 8, 1'b1);
    settle();
    chk("readback", 16'hffff, read_bits[15:0]);
    chk("input_code", 16'h1234, input_code);
    chk("dac_code held", 16'hffff, dac_code);
    host.pulse_load();
    settle();
    chk("dac_code", 16'h1234, dac_code);
    $display("test async done");
  endtask

  // Two words in one frame: old code then first word come out
  task automatic t_chain();
    host.xfer(32, {32'h0, 16'hbeef, 16'h0f0f}, 1'b1, 4, 1'b1);
    settle();
    chk("chain readback", 16'h1234, read_bits[31:16]);
    chk("chain passthru", 16'hbeef, read_bits[15:0]);
    chk("input_code", 16'h0f0f, input_code);
    chk("dac_code held", 16'h1234, dac_code);
    host.pulse_load();
    settle();
    chk("dac_code", 16'h0f0f, dac_code);
    $display("test chain done");
  endtask

  // Short frame and unframed clocks are both dropped
  task automatic t_refuse();
    host.xfer(15, {48'h0, 16'h7777}, 1'b0, 4, 1'b1);
    settle();
    chk("short input_code", 16'h0f0f, input_code);
    chk("short dac_code", 16'h0f0f, dac_code);
    host.xfer(16, {48'h0, 16'h5555}, 1'b1, 4, 1'b0);
    settle();
    chk("unframed input_code", 16'h0f0f, input_code);
    $display("test refuse done");
  endtask

  // Clear forces zero volts, keeps registers, ends at next load
  task automatic t_clear();
    @(posedge sys_clk);
    clear_n <= 1'b0;
    settle();
    chk("ladder_code", 16'h8000, ladder_code);
    chk("bipolar_code", 16'h0000, bipolar_code);
    chk("cleared", 16'h0001, {15'h0, cleared});
    chk("dac_code kept", 16'h0f0f, dac_code);
    clear_n <= 1'b1;
    settle();
    host.xfer(16, {48'h0, 16'h4321}, 1'b0, 4, 1'b1);
    settle();
    chk("ladder_code", 16'h4321, ladder_code);
    chk("cleared", 16'h0000, {15'h0, cleared});
    $display("test clear done");
  endtask

  // Power-down follows its pin
  task automatic t_pdown();
    @(posedge sys_clk);
    pdown_n <= 1'b0;
    settle();
    chk("power_down", 16'h0001, {15'h0, pdown});
    pdown_n <= 1'b1;
    settle();
    chk("power_down", 16'h0000, {15'h0, pdown});
    $display("test pdown done");
  endtask

  // Main sequence, ending with a second reset in mid-run
  initial begin
    t_reset();
    t_sync();
    t_async();
    t_chain();
    t_refuse();
    t_clear();
    t_pdown();
    t_reset();
    results();
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge sys_clk);
    failures++;
    $display("ERROR watchdog expected end seen timeout");
    results();
  end

endmodule // sdl_dac_load_tb_top
